// ---- design/sesl_top.sv ----
// Event status latch: identity, tilt position, interrupt sources, summary, release.
// Assumes event pulses come from detection engines on the same clock;
// the register read port comes from a serial front end on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sesl_top #(
    parameter logic [7:0] IDENTITY = sesl_pkg::IDENTITY_DEFAULT
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // Register read port
    input  wire logic       rd_i,
    input  wire logic       rd_burst_i,
    input  wire logic       spi_mode_i,
    input  wire logic [7:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    // Tilt engine
    input  wire logic       tilt_tick_i,
    input  wire logic [5:0] tilt_pos_i,
    input  wire logic [5:0] tilt_mask_i,
    input  wire logic       tilt_int_en_i,
    // Tap engine
    input  wire logic       tap_evt_i,
    input  wire logic [5:0] tap_dir_i,
    input  wire logic [1:0] tap_kind_i,
    input  wire logic       tap_int_en_i,
    // Free fall engine
    input  wire logic       freefall_evt_i,
    input  wire logic       freefall_int_en_i,
    // Buffer status
    input  wire logic       buf_full_evt_i,
    input  wire logic       buf_sample_rd_i,
    input  wire logic       buf_above_wm_i,
    input  wire logic       buf_trigger_mode_i,
    input  wire logic       buf_int_en_i,
    input  wire logic       wm_int_en_i,
    // New sample engine
    input  wire logic       new_sample_evt_i,
    input  wire logic       new_sample_int_en_i,
    // Wake and sleep engine
    input  wire logic       wake_evt_i,
    input  wire logic [5:0] wake_dir_i,
    input  wire logic       sleep_evt_i,
    input  wire logic       manual_doze_i,
    input  wire logic       wake_int_en_i,
    input  wire logic       sleep_int_en_i,
    // Interrupt pin and wake state
    output logic            irq_o,
    output logic            wake_state_o
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [5:0] tilt_cur;
        logic [5:0] tilt_prev;
        logic [5:0] tilt_pend_cur;
        logic [5:0] tilt_pend_prev;
        logic       tilt_pend;
        logic       tilt_chg;
        logic [5:0] tap_dir;
        logic [1:0] tap_kind;
        logic       freefall;
        logic       buf_full;
        logic       new_sample;
        logic       wake_flag;
        logic       sleep_flag;
        logic [5:0] motion_dir;
        logic       wake_state;
        logic       irq;
        logic [7:0] rd_data;
    } sesl_state_t;

    sesl_state_t s_q;
    sesl_state_t s_d;

    logic release_rd;
    logic out_data_rd;
    logic rd_busy;

    ////////////////////////////////////////////////////////////////////////
    // Read classification

    sesl_read_track u_track (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .rd_i          (rd_i),
        .burst_i       (rd_burst_i),
        .spi_mode_i    (spi_mode_i),
        .addr_i        (rd_addr_i),
        .release_o     (release_rd),
        .out_data_rd_o (out_data_rd),
        .busy_o        (rd_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Latch a flag: set wins over clear
    function automatic logic latch_flag(input logic cur, input logic set,
                                        input logic clr);
        latch_flag = set | (cur & ~clr);
    endfunction

    // Watermark flag, live from buffer level, never in trigger mode
    logic wm_flag;
    assign wm_flag = buf_above_wm_i & ~buf_trigger_mode_i;

    // Masked tilt change and summary
    logic tilt_masked;
    logic any_int;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        tilt_masked = 1'b0;
        any_int = 1'b0;

        // Tilt sample pending while a read is busy
        if (tilt_tick_i) begin
            s_d.tilt_pend      = 1'b1;
            s_d.tilt_pend_cur  = tilt_pos_i;
            s_d.tilt_pend_prev = s_q.tilt_pend ? s_q.tilt_pend_cur : s_q.tilt_cur;
        end
        if ((tilt_tick_i || s_q.tilt_pend) && !rd_busy) begin
            s_d.tilt_pend = 1'b0;
            if (tilt_tick_i) begin
                s_d.tilt_prev = s_q.tilt_pend ? s_q.tilt_pend_cur : s_q.tilt_cur;
                s_d.tilt_cur  = tilt_pos_i;
            end else begin
                s_d.tilt_prev = s_q.tilt_pend_prev;
                s_d.tilt_cur  = s_q.tilt_pend_cur;
            end
            s_d.tilt_chg = (s_d.tilt_cur != s_d.tilt_prev);
        end

        // Tap direction and kind
        s_d.tap_dir  = tap_evt_i ? (tap_dir_i | (release_rd ? 6'h00 : s_q.tap_dir))
                                 : (release_rd ? 6'h00 : s_q.tap_dir);
        s_d.tap_kind = tap_evt_i ? tap_kind_i
                                 : (release_rd ? sesl_pkg::TAP_NONE : s_q.tap_kind);

        // Function flags
        s_d.freefall   = latch_flag(s_q.freefall, freefall_evt_i, release_rd);
        s_d.buf_full   = latch_flag(s_q.buf_full, buf_full_evt_i, buf_sample_rd_i);
        s_d.new_sample = latch_flag(s_q.new_sample, new_sample_evt_i,
                                    release_rd | out_data_rd);

        // Motion flags
        s_d.wake_flag  = latch_flag(s_q.wake_flag, wake_evt_i, release_rd);
        s_d.sleep_flag = latch_flag(s_q.sleep_flag, sleep_evt_i, release_rd);
        s_d.motion_dir = wake_evt_i ? (wake_dir_i | (release_rd ? 6'h00 : s_q.motion_dir))
                                    : (release_rd ? 6'h00 : s_q.motion_dir);

        // Wake state, manual doze forces sleep unless a wake event comes in the same cycle
        if (wake_evt_i) begin
            s_d.wake_state = 1'b1;
        end else if (sleep_evt_i || manual_doze_i) begin
            s_d.wake_state = 1'b0;
        end

        // Tilt interrupt only through mask
        tilt_masked = s_q.tilt_chg && |(s_q.tilt_cur & tilt_mask_i) && tilt_int_en_i;

        // Combined interrupt
        any_int = tilt_masked
                | (tap_int_en_i && (|s_q.tap_dir || s_q.tap_kind != sesl_pkg::TAP_NONE))
                | (freefall_int_en_i && s_q.freefall)
                | (buf_int_en_i && s_q.buf_full)
                | (wm_int_en_i && wm_flag)
                | (new_sample_int_en_i && s_q.new_sample)
                | (wake_int_en_i && s_q.wake_flag)
                | (sleep_int_en_i && s_q.sleep_flag);
        s_d.irq = any_int & ~release_rd;

        // Read data mux
        unique case (rd_addr_i)
            sesl_pkg::ADDR_IDENTITY:   s_d.rd_data = IDENTITY;
            sesl_pkg::ADDR_TILT_CUR:   s_d.rd_data = {2'h0, s_q.tilt_cur};
            sesl_pkg::ADDR_TILT_PREV:  s_d.rd_data = {2'h0, s_q.tilt_prev};
            sesl_pkg::ADDR_TAP_SRC:    s_d.rd_data = {2'h0, s_q.tap_dir};
            sesl_pkg::ADDR_FUNC_SRC:   s_d.rd_data = {s_q.freefall, s_q.buf_full, wm_flag,
                                                      s_q.new_sample, s_q.tap_kind,
                                                      1'b0, s_q.tilt_chg};
            sesl_pkg::ADDR_MOTION_SRC: s_d.rd_data = {s_q.wake_flag, s_q.sleep_flag,
                                                      s_q.motion_dir};
            sesl_pkg::ADDR_SUMMARY:    s_d.rd_data = {3'h0, s_q.irq, 3'h0, s_q.wake_state};
            sesl_pkg::ADDR_RELEASE:    s_d.rd_data = 8'h00;
            default:                   s_d.rd_data = 8'h00;
        endcase
        if (!rd_i) begin
            s_d.rd_data = s_q.rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q            <= '0;
            s_q.tilt_cur   <= sesl_pkg::TILT_RESET;
            s_q.tilt_prev  <= sesl_pkg::TILT_RESET;
            s_q.wake_state <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data_o    = s_q.rd_data;
    assign irq_o        = s_q.irq;
    assign wake_state_o = s_q.wake_state;

endmodule

`default_nettype wire

// ---- design/sesl_pkg.sv ----
// Package for the event status latch block: offsets, field positions, reset values.
// Assumes a byte-wide register read port driven by a serial interface front end.
package sesl_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_IDENTITY   = 8'h13;
    localparam logic [7:0] ADDR_TILT_CUR   = 8'h14;
    localparam logic [7:0] ADDR_TILT_PREV  = 8'h15;
    localparam logic [7:0] ADDR_TAP_SRC    = 8'h16;
    localparam logic [7:0] ADDR_FUNC_SRC   = 8'h17;
    localparam logic [7:0] ADDR_MOTION_SRC = 8'h18;
    localparam logic [7:0] ADDR_SUMMARY    = 8'h19;
    localparam logic [7:0] ADDR_RELEASE    = 8'h1a;
    localparam logic [7:0] ADDR_OUT_FIRST  = 8'h08;
    localparam logic [7:0] ADDR_OUT_LAST   = 8'h0d;

    // Identity value: arbitrary neutral code
    localparam logic [7:0] IDENTITY_DEFAULT = 8'h5a;

    // Reset values
    localparam logic [5:0] TILT_RESET = 6'h20;

    // Function source bit positions
    localparam int FS_FREEFALL  = 7;
    localparam int FS_BUF_FULL  = 6;
    localparam int FS_WATERMARK = 5;
    localparam int FS_NEW_SAMP  = 4;
    localparam int FS_TAP_HI    = 3;
    localparam int FS_TAP_LO    = 2;
    localparam int FS_TILT_CHG  = 0;

    // Motion source bit positions
    localparam int MS_WAKE  = 7;
    localparam int MS_SLEEP = 6;

    // Summary bit positions
    localparam int SUM_INT  = 4;
    localparam int SUM_WAKE = 0;

    // Tap kind codes
    localparam logic [1:0] TAP_NONE   = 2'h0;
    localparam logic [1:0] TAP_SINGLE = 2'h1;
    localparam logic [1:0] TAP_DOUBLE = 2'h2;

endpackage

// ---- design/sesl_read_track.sv ----
// Read tracker: classifies each register read for the latch logic.
// Assumes rd_i is a one-cycle pulse per byte, burst_i high on continuation bytes.
`timescale 1ns/1ps
`default_nettype none

module sesl_read_track (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // Read strobe
    input  wire logic       rd_i,
    input  wire logic       burst_i,
    input  wire logic       spi_mode_i,
    input  wire logic [7:0] addr_i,
    // Classified events
    output logic            release_o,
    output logic            out_data_rd_o,
    output logic            busy_o
);

    typedef struct packed {
        logic busy;
    } sesl_trk_t;

    sesl_trk_t s_q;
    sesl_trk_t s_d;

    // Release at the release address unless an SPI burst continuation
    always_comb begin
        s_d = s_q;
        if (rd_i) begin
            s_d.busy = 1'b1;
        end else begin
            s_d.busy = 1'b0;
        end
        release_o     = rd_i && (addr_i == sesl_pkg::ADDR_RELEASE)
                        && !(burst_i && spi_mode_i);
        out_data_rd_o = rd_i && (addr_i >= sesl_pkg::ADDR_OUT_FIRST)
                        && (addr_i <= sesl_pkg::ADDR_OUT_LAST);
        busy_o        = rd_i || s_q.busy;
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/sesl_sva.sv ----
// Checker for read answers, release and pin behaviour of the latch.
// Assumes it is bound into sesl_top; one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sesl_sva #(parameter logic [7:0] IDENTITY = 8'h00) (
    // Clock, reset and read port
    input wire logic       ref_clk_i, rst_n_i, rd_i, rd_burst_i, spi_mode_i,
    input wire logic [7:0] rd_addr_i, rd_data_o,
    // Events and pins
    input wire logic       freefall_evt_i, freefall_int_en_i, buf_sample_rd_i,
    input wire logic       manual_doze_i, irq_o, wake_state_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Release read and SPI burst continuation
    wire logic rel = rd_i && rd_addr_i == 8'h1a;
    wire logic brst = rd_burst_i && spi_mode_i;
    ////////////////////////////////////////////////////////////////////////////
    property p_id; rd_i && rd_addr_i == 8'h13 |=> rd_data_o == IDENTITY; endproperty
    a_id: assert property (p_id) else $error("identity byte wrong");
    property p_tilt; rd_i && rd_addr_i inside {8'h14, 8'h15} |=> rd_data_o[7:6] == 2'h0;
    endproperty
    a_tilt: assert property (p_tilt) else $error("tilt high bits set");
    property p_sum; rd_i && rd_addr_i == 8'h19 |=> {rd_data_o[7:5], rd_data_o[3:1]} == 6'h00;
    endproperty
    a_sum: assert property (p_sum) else $error("summary zero bits set");
    property p_rel; rel |=> rd_data_o == 8'h00; endproperty
    a_rel: assert property (p_rel) else $error("release read not zero");
    property p_rel_irq; rel && !brst && !freefall_evt_i |=> !irq_o; endproperty
    a_rel_irq: assert property (p_rel_irq) else $error("pin kept after release");
    property p_burst; irq_o && rel && brst && !buf_sample_rd_i |=> irq_o; endproperty
    a_burst: assert property (p_burst) else $error("burst release cleared pin");
    property p_ff;
        freefall_evt_i && freefall_int_en_i && !rd_i ##1 !rd_i && freefall_int_en_i
            |-> ##[0:1] irq_o;
    endproperty
    a_ff: assert property (p_ff) else $error("free fall did not raise pin");
    property p_wake; $rose(rst_n_i) |-> wake_state_o; endproperty
    a_wake: assert property (p_wake) else $error("not awake after reset");
    property p_doze; manual_doze_i |=> !wake_state_o; endproperty
    a_doze: assert property (p_doze) else $error("doze did not sleep");
endmodule
bind sesl_top sesl_sva #(.IDENTITY(IDENTITY)) u_sva (.ref_clk_i, .rst_n_i, .rd_i,
    .rd_burst_i, .spi_mode_i, .rd_addr_i, .rd_data_o, .freefall_evt_i, .freefall_int_en_i,
    .buf_sample_rd_i, .manual_doze_i, .irq_o, .wake_state_o);
`default_nettype wire

// ---- testbench/sesl_host.sv ----
// Host model: issues single register reads and takes the answer.
// Assumes the latch answers on the edge after each read strobe.
`timescale 1ns/1ps
`default_nettype none
module sesl_host (
    // Clock
    input  wire logic       ref_clk_i,
    // Read port
    output var  logic       rd_o,
    output var  logic       burst_o,
    output var  logic [7:0] addr_o,
    input  wire logic [7:0] data_i
);
    // Idle port at time zero
    initial begin
        rd_o = 1'b0;
        burst_o = 1'b0;
        addr_o = 8'h00;
    end
    // One read; address inverted once released
    task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
        @(posedge ref_clk_i);
        rd_o <= 1'b1;
        burst_o <= b;
        addr_o <= a;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        burst_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = data_i;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Testbench for the event status latch: event table, then edge cases.
// Assumes the host model and bound checker are compiled with the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [3:0] k; logic [7:0] d, a, e;} sesl_row_t;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
    logic       clk, rd, burst, irq, wake;
    logic       rst_n = 1'b0, spi = 1'b0, doze = 1'b0, wm = 1'b0, trig = 1'b0;
    logic [7:0] addr, dout, rv, pls = 8'h00, en = 8'hff, dt = 8'h00;
    logic [5:0] mask = 6'h00;
    int         err_total = 0, n_compared = 0;
    // Event bit, event data, address, expected byte
    sesl_row_t rows [13] = '{'{4'hf, 8'h00, 8'h13, ID}, '{4'hf, 8'h00, 8'h14, 8'h20},
        '{4'hf, 8'h00, 8'h15, 8'h20}, '{4'hf, 8'h00, 8'h00, 8'h00},
        '{4'h2, 8'h00, 8'h17, 8'h80}, '{4'h2, 8'h00, 8'h19, 8'h11},
        '{4'h1, 8'h60, 8'h16, 8'h20}, '{4'h1, 8'h81, 8'h17, 8'h08},
        '{4'h1, 8'h41, 8'h17, 8'h04}, '{4'h4, 8'h00, 8'h17, 8'h10},
        '{4'h3, 8'h00, 8'h17, 8'h40}, '{4'h6, 8'h00, 8'h18, 8'h40},
        '{4'h5, 8'h05, 8'h18, 8'h85}};
    // Latch and host
    sesl_top #(.IDENTITY(ID)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .rd_i(rd),
        .rd_burst_i(burst), .spi_mode_i(spi), .rd_addr_i(addr), .rd_data_o(dout),
        .tilt_tick_i(pls[0]), .tilt_pos_i(dt[5:0]), .tilt_mask_i(mask), .tilt_int_en_i(en[0]),
        .tap_evt_i(pls[1]), .tap_dir_i(dt[5:0]), .tap_kind_i(dt[7:6]), .tap_int_en_i(en[1]),
        .freefall_evt_i(pls[2]), .freefall_int_en_i(en[2]), .buf_full_evt_i(pls[3]),
        .buf_sample_rd_i(pls[7]), .buf_above_wm_i(wm), .buf_trigger_mode_i(trig),
        .buf_int_en_i(en[3]), .wm_int_en_i(en[4]), .new_sample_evt_i(pls[4]),
        .new_sample_int_en_i(en[5]), .wake_evt_i(pls[5]), .wake_dir_i(dt[5:0]),
        .sleep_evt_i(pls[6]), .manual_doze_i(doze), .wake_int_en_i(en[6]),
        .sleep_int_en_i(en[7]), .irq_o(irq), .wake_state_o(wake));
    sesl_host u_host (.ref_clk_i(clk), .rd_o(rd), .burst_o(burst), .addr_o(addr), .data_i(dout));
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h, expected %h", $time, got, exp);
        end
    endtask
    // Read one register and compare
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd(a, 1'b0, v);
        chk(v, e);
    endtask
    // One-cycle event pulse with its data
    task automatic fire(input int k, input logic [7:0] d);
        @(posedge clk);
        pls <= 8'h01 << k;
        dt <= d;
        @(posedge clk);
        pls <= 8'h00;
    endtask
    // Counts and verdict
    task automatic results();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog
    initial begin
        #20us;
        err_total++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].k != 4'hf) fire(rows[i].k, rows[i].d);
            repeat (3) @(posedge clk);
            rdc(rows[i].a, rows[i].e);
            rdc(8'h1a, 8'h00);
            fire(7, 8'h00);
        end
        // Disabled sources keep the pin low
        en <= 8'h00;
        fire(2, 8'h00);
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        en <= 8'hff;
        rdc(8'h1a, 8'h00);
        // Buffer flags survive release; watermark ignored in trigger mode
        fire(3, 8'h00);
        wm <= 1'b1;
        rdc(8'h1a, 8'h00);
        rdc(8'h17, 8'h60);
        @(posedge clk);
        trig <= 1'b1;
        rdc(8'h17, 8'h40);
        fire(7, 8'h00);
        trig <= 1'b0;
        wm <= 1'b0;
        rdc(8'h17, 8'h00);
        // Burst release keeps flags, plain release clears
        fire(2, 8'h00);
        spi <= 1'b1;
        repeat (2) @(posedge clk);
        u_host.rd(8'h1a, 1'b1, rv);
        chk(rv, 8'h00);
        rdc(8'h17, 8'h80);
        rdc(8'h1a, 8'h00);
        rdc(8'h17, 8'h00);
        chk({7'h00, irq}, 8'h00);
        // Event in the clearing cycle is kept
        fork
            u_host.rd(8'h1a, 1'b0, rv);
            fire(2, 8'h00);
        join
        rdc(8'h17, 8'h80);
        rdc(8'h1a, 8'h00);
        // Data read clears the new sample flag
        fire(4, 8'h00);
        u_host.rd(8'h08, 1'b0, rv);
        rdc(8'h17, 8'h00);
        // Masked tilt stays quiet, unmasked raises the pin, read freezes tilt
        fire(0, 8'h01);
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        mask <= 6'h02;
        rdc(8'h14, 8'h01);
        rdc(8'h15, 8'h20);
        rdc(8'h17, 8'h01);
        fire(0, 8'h02);
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        fork
            u_host.rd(8'h14, 1'b0, rv);
            fire(0, 8'h04);
        join
        chk(rv, 8'h02);
        // Same position again leaves the change flag clear
        fire(0, 8'h04);
        rdc(8'h17, 8'h00);
        // Manual doze forces sleep
        @(posedge clk);
        doze <= 1'b1;
        en <= 8'h00;
        repeat (2) @(posedge clk);
        rdc(8'h19, 8'h00);
        // Mid-run reset restores power-up values
        doze <= 1'b0;
        rst_n <= 1'b0;
        @(posedge clk);
        chk({6'h00, irq, wake}, 8'h01);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h14, 8'h20);
        rdc(8'h15, 8'h20);
        rdc(8'h17, 8'h00);
        rdc(8'h19, 8'h01);
        results();
    end
endmodule
`default_nettype wire
